// >>> design/ubc_map.svh
// constants for the serial baud clock generator
// assumes one system clock at 40 MHz and no software register access
//
// Operation
// - bit rate is clock over 16, 8 or 2 times divisor plus one.
// - divisor joins a 4-bit high part and 8-bit low part, range 0-4095.
// - double speed acts only in async mode; hardware masks it in sync mode.
// - double speed gives receiver 8 samples per bit instead of 16.
// - external transfer clock is used only in synchronous slave mode.
// - external clock is synchronised, then edge detected, before use.
// - external edge reaches the transceiver strobes four system clocks late.
// - mode select one means synchronous, zero means asynchronous.
// - master drives the transfer clock pin; slave only listens to it.
// - receive samples on the edge opposite to the transmit change edge.
`ifndef UBC_MAP_SVH
`define UBC_MAP_SVH

`define UBC_DIV_W       12
`define UBC_DIV_HI_W    4
`define UBC_DIV_LO_W    8
`define UBC_DIV_ZERO    12'h000
`define UBC_OVS_W       4
`define UBC_OVS_NORMAL  4'hF
`define UBC_OVS_DOUBLE  4'h7
`define UBC_OVS_ZERO    4'h0
`define UBC_OVS_HALF_N  4'h7
`define UBC_OVS_HALF_D  4'h3
`define UBC_SYNC_LAT    2

`endif

// >>> design/ubc_pkg.sv
// types for the serial baud clock generator
// assumes ubc_map.svh supplies the numeric constants
package ubc_pkg;
    // 2-bit mode code built from sync and master select
    typedef enum logic [1:0] {
        UBC_ASYNC      = 2'b00,
        UBC_ASYNC_ALT  = 2'b01,
        UBC_SYNC_SLAVE = 2'b10,
        UBC_SYNC_MASTER = 2'b11
    } ubc_mode_type;
endpackage : ubc_pkg

// >>> design/ubc_xck_sync.sv
// synchroniser and edge detector for the external transfer clock
// assumes the input comes from a pin outside the system clock domain
`timescale 1ns/1ps
`include "ubc_map.svh"
module ubc_xck_sync (
    clk_sys,                          // system clock
    rst_sync_n,                       // synchronised reset, active low
    xck_in,                           // raw external clock pin
    rise_pulse,                       // one-cycle pulse on rising edge
    fall_pulse                        // one-cycle pulse on falling edge
);
    input  wire logic clk_sys;
    input  wire logic rst_sync_n;
    input  wire logic xck_in;
    output logic      rise_pulse;
    output logic      fall_pulse;

    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    wire  rise_w = sync_reg & ~prev_reg;
    wire  fall_w = ~sync_reg & prev_reg;

    // ===========================================================
    // sync chain, edge detect registered: three clocks of latency
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            meta_reg   <= 1'b0;
            sync_reg   <= 1'b0;
            prev_reg   <= 1'b0;
            rise_pulse <= 1'b0;
            fall_pulse <= 1'b0;
        end else begin
            meta_reg   <= xck_in;
            sync_reg   <= meta_reg;
            prev_reg   <= sync_reg;
            rise_pulse <= rise_w;
            fall_pulse <= fall_w;
        end
    end

    property p_rise_once;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        rise_pulse |=> !rise_pulse;
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("rise pulse longer than one cycle");

    property p_rise_lat;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (sync_reg && !prev_reg) |=> rise_pulse;
    endproperty
    a_rise_lat: assert property (p_rise_lat) else $error("rise edge not reported in time");
endmodule : ubc_xck_sync

// >>> design/ubc_baud_gen.sv
// baud clock generator for a synchronous/asynchronous serial port
// assumes static configuration inputs from the same clock domain;
// transfer clock pin arrives raw from the board
`timescale 1ns/1ps
`include "ubc_map.svh"
module ubc_baud_gen (
    clk_sys,                          // 40 MHz system clock
    rst_n,                            // async reset, active low
    baud_divisor_high,                // divisor bits 11:8
    baud_divisor_low,                 // divisor bits 7:0
    double_speed_sel,                 // async double speed
    sync_mode_sel,                    // 1 = synchronous
    sync_master_sel,                  // 1 = master in sync mode
    xfer_clock_pin_in,                // transfer clock pin input
    xfer_clock_pin_out,               // transfer clock pin output
    xfer_clock_pin_oe,                // transfer clock pin enable
    sample_tick,                      // oversample tick (async)
    rx_sample,                        // receive sample strobe
    tx_shift                          // transmit change strobe
);
    input  wire logic                     clk_sys;
    input  wire logic                     rst_n;
    input  wire logic [`UBC_DIV_HI_W-1:0] baud_divisor_high;
    input  wire logic [`UBC_DIV_LO_W-1:0] baud_divisor_low;
    input  wire logic                     double_speed_sel;
    input  wire logic                     sync_mode_sel;
    input  wire logic                     sync_master_sel;
    input  wire logic                     xfer_clock_pin_in;
    output logic                          xfer_clock_pin_out;
    output logic                          xfer_clock_pin_oe;
    output logic                          sample_tick;
    output logic                          rx_sample;
    output logic                          tx_shift;

    // ===========================================================
    // reset release
    logic rst_a_reg;
    logic rst_sync_n;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_a_reg  <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_a_reg  <= 1'b1;
            rst_sync_n <= rst_a_reg;
        end
    end

    // ===========================================================
    // configuration decode
    wire [`UBC_DIV_W-1:0] baud_divisor = {baud_divisor_high, baud_divisor_low};
    wire ubc_pkg::ubc_mode_type mode_w =
        ubc_pkg::ubc_mode_type'({sync_mode_sel, sync_mode_sel & sync_master_sel});
    // double speed masked out in sync mode in case software left it set
    wire dbl_eff_w = double_speed_sel & ~sync_mode_sel;
    wire [`UBC_OVS_W-1:0] ovs_top_w  = dbl_eff_w ? `UBC_OVS_DOUBLE : `UBC_OVS_NORMAL;
    wire [`UBC_OVS_W-1:0] ovs_half_w = dbl_eff_w ? `UBC_OVS_HALF_D : `UBC_OVS_HALF_N;
    wire is_master_w = (mode_w == ubc_pkg::UBC_SYNC_MASTER);
    wire is_slave_w  = (mode_w == ubc_pkg::UBC_SYNC_SLAVE);

    // ===========================================================
    // divisor down-counter
    logic [`UBC_DIV_W-1:0] cnt_reg;
    logic                  tick_reg;
    wire                   cnt_zero_w = (cnt_reg == `UBC_DIV_ZERO);
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cnt_reg  <= `UBC_DIV_ZERO;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_zero_w ? baud_divisor : cnt_reg - 1'b1;
            tick_reg <= cnt_zero_w;
        end
    end

    // ===========================================================
    // async oversample counter: 16 or 8 ticks per bit
    logic [`UBC_OVS_W-1:0] ovs_reg;
    wire ovs_wrap_w = (ovs_reg >= ovs_top_w);
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ovs_reg <= `UBC_OVS_ZERO;
        end else if (sync_mode_sel) begin
            ovs_reg <= `UBC_OVS_ZERO;
        end else if (tick_reg) begin
            ovs_reg <= ovs_wrap_w ? `UBC_OVS_ZERO : ovs_reg + 1'b1;
        end
    end

    // ===========================================================
    // master clock: toggle per tick gives clk/(2*(div+1))
    logic mclk_reg;
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mclk_reg <= 1'b0;
        end else if (!is_master_w) begin
            mclk_reg <= 1'b0;
        end else if (tick_reg) begin
            mclk_reg <= ~mclk_reg;
        end
    end

    // ===========================================================
    // external clock path
    logic ext_rise;
    logic ext_fall;
    ubc_xck_sync u_xck_sync (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_n),
        .xck_in     (xfer_clock_pin_in),
        .rise_pulse (ext_rise),
        .fall_pulse (ext_fall)
    );

    // ===========================================================
    // strobes: tx changes on rising edge, rx samples on falling
    wire m_rise_w = is_master_w & tick_reg & ~mclk_reg;
    wire m_fall_w = is_master_w & tick_reg & mclk_reg;
    wire rx_w = sync_mode_sel ? (m_fall_w | (is_slave_w & ext_fall))
                              : (tick_reg & (ovs_reg == ovs_half_w));
    wire tx_w = sync_mode_sel ? (m_rise_w | (is_slave_w & ext_rise))
                              : (tick_reg & ovs_wrap_w);

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            xfer_clock_pin_out <= 1'b0;
            xfer_clock_pin_oe  <= 1'b0;
            sample_tick        <= 1'b0;
            rx_sample          <= 1'b0;
            tx_shift           <= 1'b0;
        end else begin
            xfer_clock_pin_out <= mclk_reg;
            xfer_clock_pin_oe  <= is_master_w;
            sample_tick        <= tick_reg & ~sync_mode_sel;
            rx_sample          <= rx_w;
            tx_shift           <= tx_w;
        end
    end

    // ===========================================================
    // checks
    property p_tick_spacing;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (tick_reg && $stable(baud_divisor) && baud_divisor == 12'h002) |=> !tick_reg ##1 !tick_reg ##1 tick_reg;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick spacing not divisor plus one");

    property p_reload;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        cnt_zero_w |=> cnt_reg == $past(baud_divisor);
    endproperty
    a_reload: assert property (p_reload) else $error("counter did not reload divisor");

    property p_ovs_bound;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (!sync_mode_sel && double_speed_sel && $stable(double_speed_sel) && tick_reg && ovs_reg == 4'h7)
            |=> ovs_reg == 4'h0;
    endproperty
    a_ovs_bound: assert property (p_ovs_bound) else $error("double speed did not wrap at 8");

    property p_ovs_normal;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (!sync_mode_sel && !double_speed_sel && tick_reg && ovs_reg == 4'h7) |=> ovs_reg == 4'h8;
    endproperty
    a_ovs_normal: assert property (p_ovs_normal) else $error("normal mode wrapped early");

    property p_sync_no_dbl;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        $past(sync_mode_sel) |-> (ovs_reg == `UBC_OVS_ZERO) && !sample_tick;
    endproperty
    a_sync_no_dbl: assert property (p_sync_no_dbl) else $error("double speed active in sync mode");

    property p_oe_master;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        $rose(is_master_w) |=> xfer_clock_pin_oe;
    endproperty
    a_oe_master: assert property (p_oe_master) else $error("pin not driven in master mode");

    property p_slave_no_oe;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (!sync_mode_sel || !sync_master_sel) ##1 (!sync_mode_sel || !sync_master_sel) |-> !xfer_clock_pin_oe;
    endproperty
    a_slave_no_oe: assert property (p_slave_no_oe) else $error("pin driven outside master mode");

    property p_ext_only_slave;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (ext_rise && !is_slave_w && !is_master_w && !sync_mode_sel && !tick_reg) |=> !tx_shift;
    endproperty
    a_ext_only_slave: assert property (p_ext_only_slave) else $error("external clock used outside slave");

    property p_opposite;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        sync_mode_sel |-> !(rx_sample && tx_shift);
    endproperty
    a_opposite: assert property (p_opposite) else $error("rx and tx strobes on same edge");

    // ===========================================================
    // master and slave edge relations
    property p_master_toggle;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (is_master_w && tick_reg) |=> (mclk_reg != $past(mclk_reg));
    endproperty
    a_master_toggle: assert property (p_master_toggle) else $error("master clock did not toggle on tick");

    property p_tx_on_rise;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (is_master_w && $past(is_master_w) && tx_shift) |=> xfer_clock_pin_out;
    endproperty
    a_tx_on_rise: assert property (p_tx_on_rise) else $error("tx strobe not followed by pin rise");

    property p_rx_on_fall;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (is_master_w && $past(is_master_w) && rx_sample) |=> !xfer_clock_pin_out;
    endproperty
    a_rx_on_fall: assert property (p_rx_on_fall) else $error("rx strobe not followed by pin fall");

    property p_slave_uses_ext;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (is_slave_w && ext_rise) |=> tx_shift;
    endproperty
    a_slave_uses_ext: assert property (p_slave_uses_ext) else $error("slave ignored external rise");

    property p_async_tx_tick;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (!sync_mode_sel && !$past(sync_mode_sel) && tx_shift) |-> $past(tick_reg);
    endproperty
    a_async_tx_tick: assert property (p_async_tx_tick) else $error("async tx strobe without divider tick");
endmodule : ubc_baud_gen

// >>> verif/ubc_remote_xcvr.sv
// remote transceiver model: the clock source of a synchronous master
// assumes the bench raises run only while a frame is meant to run
`timescale 1ns/1ps
module ubc_remote_xcvr (
    clk_sys,                          // time base only
    run,                              // high while a frame runs
    half_cyc,                         // clocks per half period
    xck                               // transfer clock to the device
);
    input  wire logic       clk_sys;
    input  wire logic       run;
    input  wire logic [7:0] half_cyc;
    output logic            xck;
    logic [7:0]             cnt_reg;
    initial begin
        xck = 1'b0;
        cnt_reg = 8'h00;
    end
    // ==========================================
    // clock generation
    // idle low between frames; half_cyc of 3 or more keeps it below clk/4
    always @(posedge clk_sys) begin
        if (!run) begin
            xck <= 1'b0;
            cnt_reg <= 8'h00;
        end else if (cnt_reg >= half_cyc - 8'h01) begin
            xck <= ~xck;
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule : ubc_remote_xcvr

// >>> verif/test_usart_baud_clock_generation.sv
// self-checking bench for the baud clock generator
// assumes the remote model drives the transfer clock pin when not master
`timescale 1ns/1ps
module test_usart_baud_clock_generation;
    logic        clk_sys;
    logic        rst_n;
    logic [3:0]  baud_divisor_high;
    logic [7:0]  baud_divisor_low;
    logic        double_speed_sel;
    logic        sync_mode_sel;
    logic        sync_master_sel;
    logic        run;
    logic        xck;
    logic        pin_out;
    logic        pin_oe;
    logic        sample_tick;
    logic        rx_sample;
    logic        tx_shift;
    logic [31:0] per;
    int          num_errors;
    int          checked;
    wire  [2:0]  strobes = {tx_shift, rx_sample, sample_tick};
    wire         pin_level = pin_oe ? pin_out : xck;
    ubc_baud_gen uut (.clk_sys(clk_sys), .rst_n(rst_n), .baud_divisor_high(baud_divisor_high),
        .baud_divisor_low(baud_divisor_low), .double_speed_sel(double_speed_sel),
        .sync_mode_sel(sync_mode_sel), .sync_master_sel(sync_master_sel),
        .xfer_clock_pin_in(pin_level), .xfer_clock_pin_out(pin_out), .xfer_clock_pin_oe(pin_oe),
        .sample_tick(sample_tick), .rx_sample(rx_sample), .tx_shift(tx_shift));
    ubc_remote_xcvr remote (.clk_sys(clk_sys), .run(run), .half_cyc(8'h03), .xck(xck));
    always #12.5 clk_sys = ~clk_sys;
    // ==========================================
    // shared tasks
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // counts falling edges up to the next strobe; a hang ends the run
    task automatic wait_pulse(input int sel, output logic [31:0] cnt);
        cnt = 32'h0000_0000;
        do begin
            @(negedge clk_sys);
            cnt++;
        end while (strobes[sel] !== 1'b1 && cnt < 32'd20000);
        if (cnt >= 32'd20000) begin
            num_errors++;
            give_verdict();
        end
    endtask : wait_pulse
    task automatic setup(input logic [11:0] dv, input logic ds, input logic sm, input logic ms, input logic rn);
        @(posedge clk_sys);
        {baud_divisor_high, baud_divisor_low} <= dv;
        double_speed_sel <= ds;
        sync_mode_sel <= sm;
        sync_master_sel <= ms;
        run <= rn;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : setup
    task automatic edge_lat(input logic lvl, input int sel);
        int n = 0;
        while (xck !== ~lvl && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        while (xck !== lvl && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 100) begin
            num_errors++;
            give_verdict();
        end
        wait_pulse(sel, per);
        check(per, 32'd4);
    endtask : edge_lat
    // ==========================================
    // scenarios
    // remote clock keeps running here: it must not disturb the divider
    task automatic t_async(input logic [11:0] dv, input logic ds);
        logic [31:0] bit_len;
        bit_len = ({20'h0_0000, dv} + 32'd1) * (ds ? 32'd8 : 32'd16);
        setup(dv, ds, 1'b0, 1'b0, 1'b1);
        check({31'h0, pin_oe}, 32'h0);
        wait_pulse(0, per);
        wait_pulse(0, per);
        check(per, {20'h0_0000, dv} + 32'd1);
        wait_pulse(2, per);
        wait_pulse(2, per);
        check(per, bit_len);
        wait_pulse(1, per);
        wait_pulse(1, per);
        check(per, bit_len);
        $display("async test done");
    endtask : t_async
    task automatic t_master(input logic [11:0] dv, input logic ds);
        setup(dv, ds, 1'b1, 1'b1, 1'b0);
        check({31'h0, pin_oe}, 32'h1);
        wait_pulse(2, per);
        wait_pulse(2, per);
        check(per, ({20'h0_0000, dv} + 32'd1) * 32'd2);
        // strobe leads the pin edge by one clock, so the transceiver acts as the pin moves
        check({31'h0, pin_out}, 32'h0);
        @(negedge clk_sys);
        check({31'h0, pin_out}, 32'h1);
        wait_pulse(1, per);
        check({31'h0, pin_out}, 32'h1);
        @(negedge clk_sys);
        check({31'h0, pin_out}, 32'h0);
        $display("master test done");
    endtask : t_master
    task automatic t_slave(input logic ds);
        setup(12'h005, ds, 1'b1, 1'b0, 1'b1);
        check({31'h0, pin_oe}, 32'h0);
        edge_lat(1'b1, 2);
        edge_lat(1'b0, 1);
        wait_pulse(2, per);
        wait_pulse(2, per);
        check(per, 32'd6);
        $display("slave test done");
    endtask : t_slave
    // ==========================================
    // main sequence
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        {baud_divisor_high, baud_divisor_low} = 12'h000;
        double_speed_sel = 1'b0;
        sync_mode_sel = 1'b0;
        sync_master_sel = 1'b0;
        run = 1'b0;
        num_errors = 0;
        checked = 0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_async(12'h000, 1'b0);
        t_async(12'h102, 1'b0);
        t_async(12'h105, 1'b1);
        t_master(12'h000, 1'b0);
        t_master(12'h002, 1'b1);
        t_slave(1'b1);
        give_verdict();
    end
endmodule : test_usart_baud_clock_generation
